// ==== verilog/ccc_pkg.sv ====
// constants and types for the clock-calendar control block
`default_nettype none
package ccc_pkg;
   localparam int unsigned CLK_HZ          = 25_000_000;
   localparam int unsigned HALF_SEC_MS     = 500;
   localparam int unsigned HALF_SEC_CYCLES = CLK_HZ / 1000 * HALF_SEC_MS;
   // cycles before the second rollover in which sync is raised
   localparam int unsigned SYNC_WINDOW     = 32;
   localparam int unsigned DIV_W           = 24;
   // byte offsets on the register bus
   localparam logic [3:0]  CFG_ADDR = 4'h0;
   localparam logic [3:0]  VAL_ADDR = 4'h4;
   localparam logic [3:0]  KEY_ADDR = 4'h8;
   // configuration register bit positions
   localparam int unsigned EN_BIT   = 15;
   localparam int unsigned UNLK_BIT = 13;
   localparam int unsigned OE_BIT   = 10;
   localparam int unsigned PTR_LSB  = 8;
   localparam logic [7:0]  CAL_RESET = 8'h00;
   localparam logic [1:0]  PTR_RESET = 2'h0;
   localparam logic [1:0]  PTR_MINUTE_SECOND_PAIR = 2'h0;
   localparam logic [1:0]  PTR_YEAR   = 2'h3;
   localparam logic [7:0]  KEY_FIRST  = 8'h55;
   localparam logic [7:0]  KEY_SECOND = 8'haa;
   // bcd limits of the time fields
   localparam logic [7:0]  SEC_MAX  = 8'h59;
   localparam logic [7:0]  HOUR_MAX = 8'h23;
   localparam logic [7:0]  WDAY_MAX = 8'h06;
   localparam logic [7:0]  DAY_MAX  = 8'h31;
   localparam logic [7:0]  MON_MAX  = 8'h12;
   localparam logic [7:0]  YEAR_MAX = 8'h99;
   localparam logic [7:0]  ZERO_MIN = 8'h00;
   localparam logic [7:0]  ONE_MIN  = 8'h01;
   typedef enum logic [1:0] {KEY_IDLE, KEY_GOT_FIRST, KEY_ARMED} ccc_key_type;
endpackage : ccc_pkg
`default_nettype wire

// ==== verilog/ccc_time_if.sv ====
// link between register front end and timekeeping core
`timescale 1ns/1ps
`default_nettype none
interface ccc_time_if;
   logic [1:0]  wr_be;     // accepted window byte writes
   logic [15:0] wr_data;
   logic [1:0]  ptr;
   logic        run;       // counting enabled
   logic [7:0]  rd_lo;
   logic [7:0]  rd_hi;
   logic        half_flag;
   logic        sync_flag;
   logic        sec_tick;  // one cycle after each rollover
   modport ctrl (output wr_be, wr_data, ptr, run,
                 input rd_lo, rd_hi, half_flag, sync_flag, sec_tick);
   modport core (input wr_be, wr_data, ptr, run,
                 output rd_lo, rd_hi, half_flag, sync_flag, sec_tick);
endinterface : ccc_time_if
`default_nettype wire

// ==== verilog/ccc_time_core.sv ====
// timekeeping core: divider, half-second flag and bcd time fields
`timescale 1ns/1ps
`default_nettype none
module ccc_time_core #(
   parameter int unsigned HALF_CYCLES = ccc_pkg::HALF_SEC_CYCLES
) (
   input  wire logic  mclk_i,
   input  wire logic  rst_b_i,
   ccc_time_if.core   ti
);
   localparam logic [ccc_pkg::DIV_W-1:0] LAST =
      ccc_pkg::DIV_W'(HALF_CYCLES - 1);
   localparam logic [ccc_pkg::DIV_W-1:0] SYNC_START =
      ccc_pkg::DIV_W'(HALF_CYCLES - 1 - ccc_pkg::SYNC_WINDOW);

   logic [ccc_pkg::DIV_W-1:0] div_reg;
   logic                      half_reg;
   logic                      sync_reg;
   logic                      tick_reg;
   logic [7:0]                tv_reg [0:7];
   logic                      sec_wr;
   logic                      sec_end;
   logic [8:0] s, m, h, w, d, mo, y;

   // bcd increment with wrap to the floor; bit 8 flags the wrap
   function automatic logic [8:0] bcd_inc(input logic [7:0] v,
                                          input logic [7:0] vmax,
                                          input logic [7:0] vmin);
      if (v >= vmax)
         return {1'b1, vmin};
      else if (v[3:0] >= 4'h9)
         return {1'b0, v[7:4] + 4'h1, 4'h0};
      else
         return {1'b0, v[7:4], v[3:0] + 4'h1};
   endfunction : bcd_inc

   assign sec_wr  = ti.wr_be[0] && (ti.ptr == ccc_pkg::PTR_MINUTE_SECOND_PAIR);
   assign sec_end = ti.run && half_reg && (div_reg == LAST);

   ////////////////////////////////////////////////////////////////////
   // half-second divider; a seconds write restarts the second
   always_ff @(posedge mclk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         div_reg  <= '0;
         half_reg <= 1'b0;
      end else if (sec_wr) begin
         div_reg  <= '0;
         half_reg <= 1'b0;
      end else if (ti.run) begin
         if (div_reg == LAST) begin
            div_reg  <= '0;
            half_reg <= ~half_reg;
         end else begin
            div_reg <= div_reg + 1'b1;
         end
      end
   end

   // warning window just before the rollover, and the rollover pulse
   always_ff @(posedge mclk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         sync_reg <= 1'b0;
         tick_reg <= 1'b0;
      end else begin
         sync_reg <= ti.run && half_reg && (div_reg >= SYNC_START);
         tick_reg <= sec_end;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // carry chain; month lengths are not modelled, days run 01..31
   always_comb begin
      s  = bcd_inc(tv_reg[0], ccc_pkg::SEC_MAX,  ccc_pkg::ZERO_MIN);
      m  = bcd_inc(tv_reg[1], ccc_pkg::SEC_MAX,  ccc_pkg::ZERO_MIN);
      h  = bcd_inc(tv_reg[2], ccc_pkg::HOUR_MAX, ccc_pkg::ZERO_MIN);
      w  = bcd_inc(tv_reg[3], ccc_pkg::WDAY_MAX, ccc_pkg::ZERO_MIN);
      d  = bcd_inc(tv_reg[4], ccc_pkg::DAY_MAX,  ccc_pkg::ONE_MIN);
      mo = bcd_inc(tv_reg[5], ccc_pkg::MON_MAX,  ccc_pkg::ONE_MIN);
      y  = bcd_inc(tv_reg[6], ccc_pkg::YEAR_MAX, ccc_pkg::ZERO_MIN);
   end

   // time fields, indexed {pointer, high byte}; software write wins
   always_ff @(posedge mclk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         for (int i = 0; i < 8; i++) tv_reg[i] <= 8'h00;
         tv_reg[4] <= ccc_pkg::ONE_MIN;
         tv_reg[5] <= ccc_pkg::ONE_MIN;
      end else if (ti.wr_be != 2'h0) begin
         if (ti.wr_be[0])
            tv_reg[{ti.ptr, 1'b0}] <= ti.wr_data[7:0];
         if (ti.wr_be[1] && ti.ptr != ccc_pkg::PTR_YEAR)
            tv_reg[{ti.ptr, 1'b1}] <= ti.wr_data[15:8];
      end else if (sec_end) begin
         tv_reg[0] <= s[7:0];
         if (s[8]) begin
            tv_reg[1] <= m[7:0];
            if (m[8]) begin
               tv_reg[2] <= h[7:0];
               if (h[8]) begin
                  tv_reg[3] <= w[7:0];
                  tv_reg[4] <= d[7:0];
                  if (d[8]) begin
                     tv_reg[5] <= mo[7:0];
                     if (mo[8]) tv_reg[6] <= y[7:0];
                  end
               end
            end
         end
      end
   end

   // window read mux; the slot above the year reads zero
   assign ti.rd_lo = tv_reg[{ti.ptr, 1'b0}];
   assign ti.rd_hi = (ti.ptr == ccc_pkg::PTR_YEAR) ? 8'h00
                                                   : tv_reg[{ti.ptr, 1'b1}];
   assign ti.half_flag = half_reg;
   assign ti.sync_flag = sync_reg;
   assign ti.sec_tick  = tick_reg;

   AST_HALF_EDGE: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
      $rose(half_reg) |-> $past(div_reg) == LAST)
      else $error("half flag rose off the half-second boundary");
   AST_SYNC_BEFORE: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
      sec_end |-> sync_reg ##1 tick_reg)
      else $error("rollover without sync warning");
endmodule : ccc_time_core
`default_nettype wire

// ==== verilog/ccc_top.sv ====
// clock-calendar control and status register block on avalon-mm
//
// Chosen here: the Avalon-MM register port and the address map.
`timescale 1ns/1ps
`default_nettype none
module ccc_top #(
   parameter int unsigned HALF_SEC_CYCLES = ccc_pkg::HALF_SEC_CYCLES
) (
   input  wire logic        mclk_i,
   input  wire logic        rst_b_i,
   input  wire logic [3:0]  avs_address_i,
   input  wire logic        avs_read_i,
   input  wire logic        avs_write_i,
   input  wire logic [31:0] avs_writedata_i,
   input  wire logic [3:0]  avs_byteenable_i,
   output var  logic [31:0] avs_readdata_o,
   output var  logic        avs_waitrequest_o,
   output var  logic        cc_pin_o,
   output var  logic        cc_pin_oe_o
);
   ccc_time_if ti ();

   logic                en_reg;
   logic                unlock_reg;
   logic                oe_reg;
   logic [1:0]          ptr_reg;
   logic [7:0]          cal_reg;
   ccc_pkg::ccc_key_type key_reg;
   logic                wait_reg;
   logic [31:0]         rdata_reg;
   logic                pin_reg;
   logic                pin_oe_reg;

   logic        req;
   logic        accept;
   logic        wr_cfg;
   logic        wr_val;
   logic        wr_key;
   logic        rd_val;
   logic        cfg_hi;
   logic        ptr_step;
   logic [15:0] cfg_view;
   logic [31:0] rd_mux;

   ////////////////////////////////////////////////////////////////////
   // bus decode; an access completes at the edge waitrequest is low
   assign req    = avs_read_i || avs_write_i;
   assign accept = req && !wait_reg;
   assign wr_cfg = accept && avs_write_i
                   && (avs_address_i == ccc_pkg::CFG_ADDR);
   assign wr_val = accept && avs_write_i
                   && (avs_address_i == ccc_pkg::VAL_ADDR);
   assign wr_key = accept && avs_write_i && avs_byteenable_i[0]
                   && (avs_address_i == ccc_pkg::KEY_ADDR);
   assign rd_val = accept && avs_read_i
                   && (avs_address_i == ccc_pkg::VAL_ADDR);
   assign cfg_hi = wr_cfg && avs_byteenable_i[1];
   // pointer steps on high-byte writes and on any window read
   assign ptr_step = (wr_val && avs_byteenable_i[1]) || rd_val;

   // status view: half flag and sync come from the core, never stored
   assign cfg_view = {en_reg, 1'b0, unlock_reg, ti.sync_flag,
                      ti.half_flag, oe_reg, ptr_reg, cal_reg};

   always_comb begin
      rd_mux = 32'h0000_0000;
      unique case (avs_address_i)
         ccc_pkg::CFG_ADDR: rd_mux = {16'h0000, cfg_view};
         ccc_pkg::VAL_ADDR: rd_mux = {16'h0000, ti.rd_hi, ti.rd_lo};
         default:           rd_mux = 32'h0000_0000;
      endcase
   end

   ////////////////////////////////////////////////////////////////////
   // one wait cycle per access; read data is caught with the answer
   always_ff @(posedge mclk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         wait_reg <= 1'b1;
      end else begin
         wait_reg <= !(req && wait_reg);
      end
   end

   always_ff @(posedge mclk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         rdata_reg <= 32'h0000_0000;
      end else if (req && wait_reg && avs_read_i) begin
         rdata_reg <= rd_mux;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // unlock key sequence: 55h then aah arms exactly the next access
   always_ff @(posedge mclk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         key_reg <= ccc_pkg::KEY_IDLE;
      end else if (accept) begin
         if (wr_key && avs_writedata_i[7:0] == ccc_pkg::KEY_FIRST)
            key_reg <= ccc_pkg::KEY_GOT_FIRST;
         else if (wr_key && key_reg == ccc_pkg::KEY_GOT_FIRST
                  && avs_writedata_i[7:0] == ccc_pkg::KEY_SECOND)
            key_reg <= ccc_pkg::KEY_ARMED;
         else
            key_reg <= ccc_pkg::KEY_IDLE;
      end
   end

   // unlock may be cleared at any time, set only while armed
   always_ff @(posedge mclk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         unlock_reg <= 1'b0;
      end else if (cfg_hi) begin
         if (!avs_writedata_i[ccc_pkg::UNLK_BIT])
            unlock_reg <= 1'b0;
         else if (key_reg == ccc_pkg::KEY_ARMED)
            unlock_reg <= 1'b1;
      end
   end

   // module enable, guarded by the unlock state before this write
   always_ff @(posedge mclk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         en_reg <= 1'b0;
      end else if (cfg_hi && unlock_reg) begin
         en_reg <= avs_writedata_i[ccc_pkg::EN_BIT];
      end
   end

   // output enable and drift trim; trim is only stored here
   always_ff @(posedge mclk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         oe_reg  <= 1'b0;
         cal_reg <= ccc_pkg::CAL_RESET;
      end else if (wr_cfg) begin
         if (avs_byteenable_i[1])
            oe_reg <= avs_writedata_i[ccc_pkg::OE_BIT];
         if (avs_byteenable_i[0])
            cal_reg <= avs_writedata_i[7:0];
      end
   end

   // window pointer: direct load wins over the auto decrement
   always_ff @(posedge mclk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         ptr_reg <= ccc_pkg::PTR_RESET;
      end else if (cfg_hi) begin
         ptr_reg <= avs_writedata_i[ccc_pkg::PTR_LSB +: 2];
      end else if (ptr_step && ptr_reg != ccc_pkg::PTR_MINUTE_SECOND_PAIR) begin
         ptr_reg <= ptr_reg - 2'h1;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // pin: seconds square wave, driven only while enabled by software
   always_ff @(posedge mclk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         pin_reg    <= 1'b0;
         pin_oe_reg <= 1'b0;
      end else begin
         pin_oe_reg <= oe_reg;
         pin_reg    <= oe_reg && ti.half_flag;
      end
   end

   // window writes reach the core only while unlocked
   assign ti.wr_be   = (wr_val && unlock_reg) ? avs_byteenable_i[1:0]
                                              : 2'h0;
   assign ti.wr_data = avs_writedata_i[15:0];
   assign ti.ptr     = ptr_reg;
   assign ti.run     = en_reg;

   ccc_time_core #(
      .HALF_CYCLES (HALF_SEC_CYCLES)
   ) u_core (
      .mclk_i  (mclk_i),
      .rst_b_i (rst_b_i),
      .ti      (ti.core)
   );

   assign avs_readdata_o    = rdata_reg;
   assign avs_waitrequest_o = wait_reg;
   assign cc_pin_o          = pin_reg;
   assign cc_pin_oe_o       = pin_oe_reg;

   ////////////////////////////////////////////////////////////////////
   // checks
   AST_ENABLE_LOCKED: assert property (@(posedge mclk_i)
      disable iff (!rst_b_i)
      (cfg_hi && !unlock_reg) |=> en_reg == $past(en_reg))
      else $error("enable changed by a locked write");
   AST_SEC_WRITE_CLEARS_HALF: assert property (@(posedge mclk_i)
      disable iff (!rst_b_i)
      (wr_val && unlock_reg && avs_byteenable_i[0]
       && ptr_reg == ccc_pkg::PTR_MINUTE_SECOND_PAIR) |=> !ti.half_flag)
      else $error("half flag not cleared by seconds write");
   AST_WINDOW_LOCKED: assert property (@(posedge mclk_i)
      disable iff (!rst_b_i)
      (ti.wr_be != 2'h0) |-> unlock_reg && wr_val)
      else $error("window write passed while locked");
   AST_PIN_OE: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
      !oe_reg |=> !cc_pin_oe_o && !cc_pin_o)
      else $error("pin driven while output disabled");
   AST_HALF_RO: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
      (cfg_hi && ti.half_flag && !ti.sync_flag) |=> ti.half_flag)
      else $error("half flag disturbed by a write");
   AST_PTR_DEC: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
      (ptr_step && !cfg_hi && ptr_reg != 2'h0)
      |=> ptr_reg == $past(ptr_reg) - 2'h1)
      else $error("pointer did not step down");
   AST_PTR_FLOOR: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
      (rd_val && ptr_reg == 2'h0) |=> ptr_reg == 2'h0)
      else $error("pointer wrapped below zero");
   AST_YEAR_HIGH_ZERO: assert property (@(posedge mclk_i)
      disable iff (!rst_b_i)
      (req && wait_reg && avs_read_i && avs_address_i == ccc_pkg::VAL_ADDR
       && ptr_reg == ccc_pkg::PTR_YEAR) |=> avs_readdata_o[15:8] == 8'h00)
      else $error("year high byte not zero");
   AST_UNLOCK_ARMED: assert property (@(posedge mclk_i)
      disable iff (!rst_b_i)
      $rose(unlock_reg) |-> $past(key_reg) == ccc_pkg::KEY_ARMED)
      else $error("unlock set without key sequence");
   AST_ONE_WAIT: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
      (req && wait_reg) |=> !avs_waitrequest_o ##1 avs_waitrequest_o)
      else $error("answer not after exactly one wait cycle");
endmodule : ccc_top
`default_nettype wire

// ==== verification/ccc_testbench.sv ====
// self-checking bench for the clock-calendar control register block
`timescale 1ns/1ps
`default_nettype none
module testbench;
   // short half second keeps the run brief; expectations derive from it
   localparam int unsigned HALF = 64;
   logic        mclk_i;
   logic        rst_b_i;
   logic [3:0]  avs_address_i;
   logic        avs_read_i;
   logic        avs_write_i;
   logic [31:0] avs_writedata_i;
   logic [3:0]  avs_byteenable_i;
   logic [31:0] avs_readdata_o;
   logic        avs_waitrequest_o;
   logic        cc_pin_o;
   logic        cc_pin_oe_o;
   int          errors;
   int          n_compared;
   logic [15:0] rd;
   int          cnt;
   logic [15:0] exp_tbl [4];

   ccc_top #(.HALF_SEC_CYCLES(HALF)) dut (
      .mclk_i            (mclk_i),
      .rst_b_i           (rst_b_i),
      .avs_address_i     (avs_address_i),
      .avs_read_i        (avs_read_i),
      .avs_write_i       (avs_write_i),
      .avs_writedata_i   (avs_writedata_i),
      .avs_byteenable_i  (avs_byteenable_i),
      .avs_readdata_o    (avs_readdata_o),
      .avs_waitrequest_o (avs_waitrequest_o),
      .cc_pin_o          (cc_pin_o),
      .cc_pin_oe_o       (cc_pin_oe_o)
   );

   ////////////////////////////////////////////////////////////////////////
   // clock at 25 mhz
   initial begin
      mclk_i = 1'b0;
      forever #20 mclk_i = ~mclk_i;
   end

   ////////////////////////////////////////////////////////////////////////
   // verdict; shared by the main sequence and the watchdog
   task automatic final_report;
      if (errors == 0 && n_compared > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask : final_report

   // compare and count
   task automatic check(input logic [15:0] got, input logic [15:0] exp);
      n_compared++;
      if (got !== exp) begin
         errors++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : check

   // one avalon access; request held until waitrequest is seen low
   task automatic bus(input logic wr, input logic [3:0] addr,
                      input logic [15:0] data, input logic [3:0] be);
      int n;
      n = 0;
      @(posedge mclk_i);
      avs_address_i    <= addr;
      avs_writedata_i  <= {16'h0000, data};
      avs_byteenable_i <= be;
      avs_write_i      <= wr;
      avs_read_i       <= ~wr;
      do begin
         @(posedge mclk_i);
         n++;
      end while (avs_waitrequest_o !== 1'b0 && n < 100);
      // a missing answer counts as a mismatch, not a hang
      if (n >= 100) begin
         errors++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, 1'b1, 1'b0);
      end
      rd = avs_readdata_o[15:0];
      avs_write_i <= 1'b0;
      avs_read_i  <= 1'b0;
   endtask : bus

   task automatic cfg_wr(input logic [15:0] d);
      bus(1'b1, ccc_pkg::CFG_ADDR, d, 4'h2);
   endtask : cfg_wr

   task automatic val_wr(input logic [15:0] d, input logic [3:0] be);
      bus(1'b1, ccc_pkg::VAL_ADDR, d, be);
   endtask : val_wr

   // both key bytes in order
   task automatic keys;
      bus(1'b1, ccc_pkg::KEY_ADDR, {8'h00, ccc_pkg::KEY_FIRST}, 4'h1);
      bus(1'b1, ccc_pkg::KEY_ADDR, {8'h00, ccc_pkg::KEY_SECOND}, 4'h1);
   endtask : keys

   // read, mask, compare
   task automatic rdchk(input logic [3:0] addr, input logic [3:0] be,
                        input logic [15:0] mask, input logic [15:0] exp);
      bus(1'b0, addr, 16'h0000, be);
      check(rd & mask, exp);
   endtask : rdchk

   // edges until the pin shows lvl, bounded
   task automatic wait_pin(input logic lvl);
      cnt = 0;
      while (cc_pin_o !== lvl && cnt < 500) begin
         @(posedge mclk_i);
         cnt++;
      end
   endtask : wait_pin

   ////////////////////////////////////////////////////////////////////////
   // watchdog: whole sequence needs well under 3000 cycles
   initial begin
      repeat (20000) @(posedge mclk_i);
      errors++;
      final_report();
   end

   ////////////////////////////////////////////////////////////////////////
   // main sequence
   initial begin
      rst_b_i          = 1'b0;
      avs_address_i    = 4'h0;
      avs_read_i       = 1'b0;
      avs_write_i      = 1'b0;
      avs_writedata_i  = 32'h0000_0000;
      avs_byteenable_i = 4'h0;
      errors           = 0;
      n_compared       = 0;
      exp_tbl          = '{16'h0099, 16'h1231, 16'h0623, 16'h5958};
      repeat (5) @(posedge mclk_i);
      rst_b_i <= 1'b1;
      // reset state, unmapped and key reads
      rdchk(ccc_pkg::CFG_ADDR, 4'h3, 16'hffff, 16'h0000);
      check({15'h0000, cc_pin_oe_o}, 16'h0000);
      rdchk(4'hc, 4'h3, 16'hffff, 16'h0000);
      rdchk(ccc_pkg::KEY_ADDR, 4'h3, 16'hffff, 16'h0000);
      // enable write while locked is dropped
      cfg_wr(16'h8000);
      rdchk(ccc_pkg::CFG_ADDR, 4'h3, 16'hffff, 16'h0000);
      // key sequence broken by a read does not unlock
      keys();
      rdchk(ccc_pkg::KEY_ADDR, 4'h3, 16'hffff, 16'h0000);
      cfg_wr(16'h2000);
      rdchk(ccc_pkg::CFG_ADDR, 4'h3, 16'hffff, 16'h0000);
      // locked window write leaves time alone
      val_wr(16'h0030, 4'h1);
      rdchk(ccc_pkg::VAL_ADDR, 4'h3, 16'hffff, 16'h0000);
      // proper unlock, pointer loaded with year
      keys();
      cfg_wr(16'h2300);
      rdchk(ccc_pkg::CFG_ADDR, 4'h3, 16'hffff, 16'h2300);
      // fill all pairs from year down, pointer steps after each write until it reaches 00
      for (int i = 0; i < 4; i++) begin
         val_wr(exp_tbl[i], 4'h3);
      end
      rdchk(ccc_pkg::CFG_ADDR, 4'h3, 16'hffff, 16'h2000);
      // reads walk the pointer down and stick at 00
      cfg_wr(16'h2300);
      for (int i = 0; i < 4; i++) begin
         rdchk(ccc_pkg::VAL_ADDR, 4'h3, 16'hffff, exp_tbl[i]);
      end
      rdchk(ccc_pkg::VAL_ADDR, 4'h3, 16'hffff, 16'h5958);
      // single byte reads decrement as well
      cfg_wr(16'h2200);
      rdchk(ccc_pkg::VAL_ADDR, 4'h1, 16'hffff, 16'h1231);
      rdchk(ccc_pkg::VAL_ADDR, 4'h2, 16'hffff, 16'h0623);
      // relocked: high write moves pointer but data is dropped
      cfg_wr(16'h0100);
      val_wr(16'h1111, 4'h3);
      rdchk(ccc_pkg::CFG_ADDR, 4'h3, 16'hffff, 16'h0000);
      rdchk(ccc_pkg::VAL_ADDR, 4'h3, 16'hffff, 16'h5958);
      // enable in the same write that unlocks is not taken
      keys();
      cfg_wr(16'ha000);
      rdchk(ccc_pkg::CFG_ADDR, 4'h3, 16'hffff, 16'h2000);
      cfg_wr(16'ha400);
      rdchk(ccc_pkg::CFG_ADDR, 4'h3, 16'he7ff, 16'ha400);
      check({15'h0000, cc_pin_oe_o}, 16'h0001);
      // seconds write restarts divider; measure both half periods
      val_wr(16'h0010, 4'h1);
      wait_pin(1'b1);
      wait_pin(1'b0);
      check(cnt[15:0], HALF[15:0]);
      wait_pin(1'b1);
      check(cnt[15:0], HALF[15:0]);
      rdchk(ccc_pkg::VAL_ADDR, 4'h3, 16'hffff, 16'h5911);
      // flag bit ignores writes; sync low early in the second half of the second
      cfg_wr(16'ha400);
      rdchk(ccc_pkg::CFG_ADDR, 4'h3, 16'h1800, 16'h0800);
      // close to the rollover the sync flag warns
      repeat (36) @(posedge mclk_i);
      rdchk(ccc_pkg::CFG_ADDR, 4'h3, 16'h1800, 16'h1800);
      // seconds write while flag high clears it
      val_wr(16'h0020, 4'h1);
      rdchk(ccc_pkg::CFG_ADDR, 4'h3, 16'h0800, 16'h0000);
      // output disabled: pin stays quiet over a whole second
      cfg_wr(16'ha000);
      repeat (2) @(posedge mclk_i);
      for (int i = 0; i < 2 * HALF + 4; i++) begin
         @(posedge mclk_i);
         check({14'h0000, cc_pin_oe_o, cc_pin_o}, 16'h0000);
      end
      final_report();
   end
endmodule : testbench
`default_nettype wire
